// ==== hdl/rtc_pkg.sv ====
/*
  rtc_pkg: register offsets, field positions, implemented-bit masks, timing
  constants and small bcd helpers shared by the timekeeping core.
  assumes a single 20 MHz system clock and a 32.768 kHz crystal input.
*/
`default_nettype none
package rtc_pkg;
  // system and crystal rates
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned OSC_STOP_US = 200; // no crystal edge this long means stopped
  localparam int unsigned OSC_STOP_CYC = (CLK_HZ / 1_000_000) * OSC_STOP_US;
  // prescaler: 32768 crystal ticks per second, trim applied every tenth second
  localparam logic [15:0] PRESC_LAST = 16'h7FFF;
  localparam logic [3:0] TRIM_WIN_LAST = 4'h9;
  // register offsets
  localparam logic [3:0] A_SEC = 4'h0;
  localparam logic [3:0] A_MIN = 4'h1;
  localparam logic [3:0] A_HOUR = 4'h2;
  localparam logic [3:0] A_WDAY = 4'h3;
  localparam logic [3:0] A_DATE = 4'h4;
  localparam logic [3:0] A_MON = 4'h5;
  localparam logic [3:0] A_YEAR = 4'h6;
  localparam logic [3:0] A_TRIM = 4'h7;
  localparam logic [3:0] A_WK_MIN = 4'h8;
  localparam logic [3:0] A_WK_HOUR = 4'h9;
  localparam logic [3:0] A_WK_DAYS = 4'hA;
  localparam logic [3:0] A_MO_MIN = 4'hB; // bank 1: monthly alarm day
  localparam logic [3:0] A_MO_HOUR = 4'hC; // bank 1: monthly alarm month
  localparam logic [3:0] A_RAM = 4'hD;
  localparam logic [3:0] A_CTRL1 = 4'hE;
  localparam logic [3:0] A_CTRL2 = 4'hF;
  // implemented bits of the counters
  localparam logic [7:0] M_SEC = 8'h7F;
  localparam logic [7:0] M_MIN = 8'h7F;
  localparam logic [7:0] M_HOUR = 8'hBF;
  localparam logic [7:0] M_WDAY = 8'h07;
  localparam logic [7:0] M_DATE = 8'h3F;
  localparam logic [7:0] M_MON = 8'h1F;
  // control 1 fields
  localparam int B_WK_EN = 7;
  localparam int B_MO_EN = 6;
  // control 2 fields
  localparam int B_BANK = 7;
  localparam int B_LOW_BATTERY_FLAG = 6;
  localparam int B_OSC_STOP_FLAG = 5;
  localparam int B_PON = 4;
  localparam int B_PERIODIC_EVENT_FLAG = 2;
  localparam int B_WKAF = 1;
  localparam int B_MOAF = 0;
  // hour register mode bit and alarm compare enables
  localparam int B_H24 = 7;
  localparam int B_CMP_EN = 7;
  // periodic select codes
  localparam logic [2:0] PER_2HZ = 3'h1;
  localparam logic [2:0] PER_1HZ = 3'h2;
  localparam logic [2:0] PER_SEC = 3'h3;
  localparam logic [2:0] PER_MIN = 3'h4;
  localparam logic [2:0] PER_HOUR = 3'h5;
  localparam logic [2:0] PER_MON = 3'h6;
  // serial command byte: read when this bit is set
  localparam int B_CMD_RD = 3;

  // bcd increment of a two-digit value, no wrap
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction : bcd_inc

  // two-digit year divisible by four
  function automatic logic is_leap(input logic [7:0] y);
    return y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
  endfunction : is_leap

  // last bcd date of a month
  function automatic logic [7:0] last_day(input logic [7:0] m, input logic [7:0] y);
    case (m[4:0])
      5'h02: return is_leap(y) ? 8'h29 : 8'h28;
      5'h04, 5'h06, 5'h09, 5'h11: return 8'h30;
      default: return 8'h31;
    endcase
  endfunction : last_day
endpackage : rtc_pkg
`default_nettype wire

// ==== hdl/osc_monitor.sv ====
/*
  osc_monitor: brings the crystal pin into the system clock, gives one
  tick per crystal rising edge, an untrimmed copy of the crystal and a
  stopped level. assumes the crystal is far slower than i_clk.
*/
`default_nettype none
module osc_monitor
  import rtc_pkg::*;
#(
  parameter int unsigned STOP_CYC = OSC_STOP_CYC
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // crystal pin
  input wire logic i_osc,
  // results
  output logic o_tick,
  output logic o_freq,
  output logic o_stopped
);
  // the idle counter is 16 bits wide and needs at least two steps
  if (STOP_CYC < 2 || STOP_CYC > 65535) begin : g_bad_stop_cyc
    $error("osc_monitor: STOP_CYC out of range");
  end

  typedef struct packed {
    logic meta;       // first sync stage, read only by the second
    logic sync;       // second sync stage
    logic last;       // previous synced level for edge detection
    logic tick;
    logic stopped;
    logic [15:0] idle;  // cycles since the last crystal edge
  } osc_state_t;

  osc_state_t q;
  osc_state_t n;

  // edge detect and stop watchdog
  always_comb begin
    n = q;
    n.meta = i_osc;
    n.sync = q.meta;
    n.last = q.sync;
    n.tick = q.sync & ~q.last;
    if (q.sync != q.last) begin
      n.idle = 16'h0000;
      n.stopped = 1'b0;
    end else if (q.idle == 16'(STOP_CYC - 1)) begin
      n.stopped = 1'b1;  // hold count, keep flagging until edges return
    end else begin
      n.idle = q.idle + 16'h0001;
    end
  end

  // state register
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign o_tick = q.tick;
  assign o_freq = q.last;  // straight crystal copy, no trim involved
  assign o_stopped = q.stopped;
endmodule : osc_monitor
`default_nettype wire

// ==== hdl/serial_port.sv ====
/*
  serial_port: four-wire serial slave. first byte after chip enable is
  the command (address in the upper nibble, read bit), then data bytes
  with auto-increment, msb first. assumes sclk far below i_clk / 8.
*/
`default_nettype none
module serial_port
  import rtc_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // pins
  input wire logic i_sclk,
  input wire logic i_si,
  input wire logic i_ce,
  output logic o_so,
  output logic o_so_oe,
  // register side
  output logic [3:0] o_addr,
  input wire logic [7:0] i_rdata,
  output logic o_wr,
  output logic [7:0] o_wdata
);
  typedef enum logic [1:0] {SP_IDLE, SP_CMD, SP_DATA} sp_phase_t;

  typedef struct packed {
    logic [2:0] meta;   // first sync stages of sclk, si, ce
    logic [2:0] sync;   // second sync stages
    logic sclk_last;
    sp_phase_t phase;
    logic rd;
    logic [2:0] bits;
    logic [7:0] rx;
    logic [7:0] tx;
    logic [3:0] addr;
    logic so;
    logic so_oe;
    logic wr;
    logic [7:0] wdata;
  } sp_state_t;

  sp_state_t q;
  sp_state_t n;
  logic rise;
  logic fall;
  logic [7:0] byte_in;

  // shift engine
  always_comb begin
    n = q;
    n.meta = {i_sclk, i_si, i_ce};
    n.sync = q.meta;
    n.sclk_last = q.sync[2];
    n.wr = 1'b0;
    rise = q.sync[2] & ~q.sclk_last;
    fall = ~q.sync[2] & q.sclk_last;
    byte_in = {q.rx[6:0], q.sync[1]};
    // a written word steps the address only after its strobe has used it
    if (q.wr) begin
      n.addr = q.addr + 4'h1;
    end
    if (!q.sync[0]) begin
      // deselected: drop the frame, release the data line
      n.phase = SP_IDLE;
      n.bits = 3'h0;
      n.so_oe = 1'b0;
      n.so = 1'b0;
    end else begin
      if (q.phase == SP_IDLE) begin
        n.phase = SP_CMD;
      end
      if (rise) begin
        n.rx = byte_in;
        n.bits = q.bits + 3'h1;
        if (q.bits == 3'h7) begin
          if (q.phase == SP_DATA) begin
            n.wr = ~q.rd;
            n.wdata = byte_in;
            if (q.rd) begin
              n.addr = q.addr + 4'h1;  // reads move on at once for the next byte
            end
          end else begin
            n.addr = byte_in[7:4];
            n.rd = byte_in[B_CMD_RD];
            n.phase = SP_DATA;
          end
        end
      end
      if (fall && q.phase == SP_DATA && q.rd) begin
        // first bit of each byte loads the word at the current address
        n.so_oe = 1'b1;
        if (q.bits == 3'h0) begin
          n.so = i_rdata[7];
          n.tx = {i_rdata[6:0], 1'b0};
        end else begin
          n.so = q.tx[7];
          n.tx = {q.tx[6:0], 1'b0};
        end
      end
    end
  end

  // state register
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign o_so = q.so;
  assign o_so_oe = q.so_oe;
  assign o_addr = q.addr;
  assign o_wr = q.wr;
  assign o_wdata = q.wdata;
endmodule : serial_port
`default_nettype wire

// ==== hdl/rtc_calendar_alarm_core.sv ====
/*
  rtc_calendar_alarm_core: bcd clock and calendar, rate trim, periodic
  interrupt, weekly and monthly alarms, reliability flags, user ram,
  all reached over the four-wire serial port in two banks.
  assumes i_rst_b is the power-on reset and pins are asynchronous.
*/
`default_nettype none
module rtc_calendar_alarm_core
  import rtc_pkg::*;
#(
  parameter int unsigned STOP_CYC = OSC_STOP_CYC
) (
  // clock and power-on reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // crystal and battery comparator pins
  input wire logic i_osc,
  input wire logic i_batt_low,
  // serial bus pins
  input wire logic i_sclk,
  input wire logic i_si,
  input wire logic i_ce,
  output logic o_so,
  output logic o_so_oe,
  // open-drain interrupt, low when driven
  output logic o_int_b_out,
  output logic o_int_b_oe,
  // crystal frequency pin
  output logic o_crystal_freq_pin
);
  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] wday;
    logic [7:0] date;
    logic [7:0] mon;
    logic [7:0] year;
    logic [7:0] trim;
    logic [7:0] wk_min;
    logic [7:0] wk_hour;
    logic [7:0] wk_days;
    logic [7:0] mo_min;
    logic [7:0] mo_hour;
    logic [7:0] mo_day;
    logic [7:0] mo_mon;
    logic [7:0] ram;
    logic [7:0] ctl1;
    logic bank;
    logic low_battery_flag;
    logic osc_stop_flag;
    logic power_on_flag;
    logic periodic_event_flag;
    logic wkaf;
    logic moaf;
    logic [15:0] presc;   // crystal ticks within the current second
    logic [3:0] win;      // second within the ten-second trim window
    logic bat_meta;       // first battery sync stage
    logic bat_sync;
    logic [3:0] evt;      // {month, hour, minute, second} rolled last cycle
    logic int_oe;
  } core_state_t;

  core_state_t q;
  core_state_t n;

  // helper wires
  logic osc_tick;
  logic osc_freq;
  logic osc_stopped;
  logic [3:0] bus_addr;
  logic [7:0] bus_rdata;
  logic bus_wr;
  logic [7:0] bus_wdata;
  logic [15:0] term;      // last prescaler count of this second
  logic sec_evt;
  logic e_min;
  logic e_hour;
  logic e_day;
  logic e_mon;
  logic e_year;
  logic [7:0] h_inc;
  logic [2:0] per;
  logic pulse_mode;
  logic per_hit;
  logic wk_hit;
  logic mo_hit;
  logic [7:0] ctl2_rd;

  // crystal synchroniser, watchdog and untrimmed copy
  osc_monitor #(
    .STOP_CYC(STOP_CYC)
  ) u_osc (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_osc(i_osc),
    .o_tick(osc_tick),
    .o_freq(osc_freq),
    .o_stopped(osc_stopped)
  );

  // host serial slave
  serial_port u_port (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_sclk(i_sclk),
    .i_si(i_si),
    .i_ce(i_ce),
    .o_so(o_so),
    .o_so_oe(o_so_oe),
    .o_addr(bus_addr),
    .i_rdata(bus_rdata),
    .o_wr(bus_wr),
    .o_wdata(bus_wdata)
  );

  // read mux, bank selects the lower registers
  always_comb begin
    ctl2_rd = {q.bank, q.low_battery_flag, q.osc_stop_flag, q.power_on_flag, 1'b0, q.periodic_event_flag, q.wkaf, q.moaf};
    bus_rdata = 8'h00;  // stamps and reserved words read zero
    if (bus_addr == A_TRIM) begin
      bus_rdata = q.trim;
    end else if (bus_addr == A_RAM) begin
      bus_rdata = q.ram;
    end else if (bus_addr == A_CTRL1) begin
      bus_rdata = q.ctl1;
    end else if (bus_addr == A_CTRL2) begin
      bus_rdata = ctl2_rd;
    end else if (q.bank) begin
      if (bus_addr == A_MO_MIN) begin
        bus_rdata = q.mo_day;
      end else if (bus_addr == A_MO_HOUR) begin
        bus_rdata = q.mo_mon;
      end
    end else if (bus_addr == A_SEC) begin
      bus_rdata = q.sec;
    end else if (bus_addr == A_MIN) begin
      bus_rdata = q.min;
    end else if (bus_addr == A_HOUR) begin
      bus_rdata = q.hour;
    end else if (bus_addr == A_WDAY) begin
      bus_rdata = q.wday;
    end else if (bus_addr == A_DATE) begin
      bus_rdata = q.date;
    end else if (bus_addr == A_MON) begin
      bus_rdata = q.mon;
    end else if (bus_addr == A_YEAR) begin
      bus_rdata = q.year;
    end else if (bus_addr == A_WK_MIN) begin
      bus_rdata = q.wk_min;
    end else if (bus_addr == A_WK_HOUR) begin
      bus_rdata = q.wk_hour;
    end else if (bus_addr == A_WK_DAYS) begin
      bus_rdata = q.wk_days;
    end else if (bus_addr == A_MO_MIN) begin
      bus_rdata = q.mo_min;
    end else if (bus_addr == A_MO_HOUR) begin
      bus_rdata = q.mo_hour;
    end
  end

  // timekeeping, flags, alarms and host writes
  always_comb begin
    n = q;
    e_min = 1'b0;
    e_hour = 1'b0;
    e_day = 1'b0;
    e_mon = 1'b0;
    e_year = 1'b0;
    h_inc = bcd_inc({2'b00, q.hour[5:0]});
    per = q.ctl1[2:0];
    pulse_mode = (per == PER_2HZ) || (per == PER_1HZ);
    n.bat_meta = i_batt_low;
    n.bat_sync = q.bat_meta;
    n.evt = 4'h0;

    // host flag clears first so a same-cycle hardware set wins
    if (bus_wr && bus_addr == A_CTRL2) begin
      n.bank = bus_wdata[B_BANK];
      if (!bus_wdata[B_LOW_BATTERY_FLAG]) n.low_battery_flag = 1'b0;
      if (!bus_wdata[B_OSC_STOP_FLAG]) n.osc_stop_flag = 1'b0;
      if (!bus_wdata[B_PON]) n.power_on_flag = 1'b0;
      if (!bus_wdata[B_PERIODIC_EVENT_FLAG]) n.periodic_event_flag = 1'b0;
      if (!bus_wdata[B_WKAF]) n.wkaf = 1'b0;
      if (!bus_wdata[B_MOAF]) n.moaf = 1'b0;
    end

    // the tenth second of each window is stretched or shortened by the trim
    if (q.win == TRIM_WIN_LAST) begin
      term = PRESC_LAST - {{9{q.trim[6]}}, q.trim[6:0]};
    end else begin
      term = PRESC_LAST;
    end
    sec_evt = osc_tick && (q.presc >= term);
    if (osc_tick) begin
      n.presc = sec_evt ? 16'h0000 : q.presc + 16'h0001;
    end

    // calendar cascade, one step per second
    if (sec_evt) begin
      n.win = (q.win == TRIM_WIN_LAST) ? 4'h0 : q.win + 4'h1;
      // comparator sampled once a second only, for low battery drain
      if (q.bat_sync) n.low_battery_flag = 1'b1;
      e_min = (q.sec == 8'h59);
      n.sec = e_min ? 8'h00 : bcd_inc(q.sec);
      if (e_min) begin
        e_hour = (q.min == 8'h59);
        n.min = e_hour ? 8'h00 : bcd_inc(q.min);
      end
      if (e_hour) begin
        if (q.hour[B_H24]) begin
          e_day = (q.hour[5:0] == 6'h23);
          n.hour = {2'b10, e_day ? 6'h00 : h_inc[5:0]};
        end else if (q.hour[4:0] == 5'h12) begin
          n.hour = {2'b00, q.hour[5], 5'h01};
        end else if (q.hour[4:0] == 5'h11) begin
          // 11 pm to 12 am ends the day, bit 5 is the pm marker
          e_day = q.hour[5];
          n.hour = {2'b00, ~q.hour[5], 5'h12};
        end else begin
          n.hour = {2'b00, q.hour[5], h_inc[4:0]};
        end
      end
      if (e_day) begin
        n.wday = (q.wday[2:0] == 3'h6) ? 8'h00 : q.wday + 8'h01;
        e_mon = (q.date == last_day(q.mon, q.year));
        n.date = e_mon ? 8'h01 : bcd_inc(q.date);
      end
      if (e_mon) begin
        e_year = (q.mon == 8'h12);
        n.mon = e_year ? 8'h01 : bcd_inc(q.mon);
      end
      if (e_year) begin
        // no century rule: 00 after 99 is treated as leap as well
        n.year = (q.year == 8'h99) ? 8'h00 : bcd_inc(q.year);
      end
      n.evt = {e_mon, e_hour, e_min, 1'b1};
    end

    // oscillator watchdog
    if (osc_stopped) n.osc_stop_flag = 1'b1;

    // alarms compare one cycle after the minute rolled, on updated time
    wk_hit = (q.min == q.wk_min) && (q.hour[5:0] == q.wk_hour[5:0])
           && q.wk_days[q.wday[2:0]];
    mo_hit = (q.min == q.mo_min) && (q.hour[5:0] == q.mo_hour[5:0])
           && (!q.mo_day[B_CMP_EN] || q.date[5:0] == q.mo_day[5:0])
           && (!q.mo_mon[B_CMP_EN] || q.mon[4:0] == q.mo_mon[4:0]);
    if (q.evt[1] && wk_hit) n.wkaf = 1'b1;
    if (q.evt[1] && mo_hit) n.moaf = 1'b1;

    // periodic: pulse modes follow the prescaler, level modes latch
    case (per)
      PER_SEC: per_hit = q.evt[0];
      PER_MIN: per_hit = q.evt[1];
      PER_HOUR: per_hit = q.evt[2];
      PER_MON: per_hit = q.evt[3];
      default: per_hit = 1'b0;
    endcase
    if (per == PER_2HZ) begin
      n.periodic_event_flag = ~q.presc[13];
    end else if (per == PER_1HZ) begin
      n.periodic_event_flag = ~q.presc[14];
    end else if (per_hit) begin
      n.periodic_event_flag = 1'b1;
    end else if (pulse_mode == 1'b0 && q.periodic_event_flag && n.periodic_event_flag == 1'b0) begin
      n.periodic_event_flag = 1'b0;  // host cleared the latched event
    end

    // host data writes override counting; masked bits stay zero
    if (bus_wr) begin
      if (bus_addr == A_TRIM) begin
        n.trim = bus_wdata;
      end else if (bus_addr == A_RAM) begin
        n.ram = bus_wdata;
      end else if (bus_addr == A_CTRL1) begin
        n.ctl1 = bus_wdata;
        if (bus_wdata[2:0] != per) n.periodic_event_flag = 1'b0;  // new rate starts idle
      end else if (bus_addr == A_CTRL2) begin
        n.bank = bus_wdata[B_BANK];
      end else if (q.bank) begin
        if (bus_addr == A_MO_MIN) begin
          n.mo_day = bus_wdata;
        end else if (bus_addr == A_MO_HOUR) begin
          n.mo_mon = bus_wdata;
        end
      end else if (bus_addr == A_SEC) begin
        n.sec = bus_wdata & M_SEC;
        n.presc = 16'h0000;
      end else if (bus_addr == A_MIN) begin
        n.min = bus_wdata & M_MIN;
      end else if (bus_addr == A_HOUR) begin
        n.hour = bus_wdata & M_HOUR;
      end else if (bus_addr == A_WDAY) begin
        n.wday = bus_wdata & M_WDAY;
      end else if (bus_addr == A_DATE) begin
        n.date = bus_wdata & M_DATE;
      end else if (bus_addr == A_MON) begin
        n.mon = bus_wdata & M_MON;
      end else if (bus_addr == A_YEAR) begin
        n.year = bus_wdata;
      end else if (bus_addr == A_WK_MIN) begin
        n.wk_min = bus_wdata;
      end else if (bus_addr == A_WK_HOUR) begin
        n.wk_hour = bus_wdata;
      end else if (bus_addr == A_WK_DAYS) begin
        n.wk_days = bus_wdata;
      end else if (bus_addr == A_MO_MIN) begin
        n.mo_min = bus_wdata;
      end else if (bus_addr == A_MO_HOUR) begin
        n.mo_hour = bus_wdata;
      end
    end

    // interrupt pin: alarms only through their enables, periodic flag in every mode from 1 to 6
    n.int_oe = (q.wkaf && q.ctl1[B_WK_EN])
             || (q.moaf && q.ctl1[B_MO_EN])
             || (q.periodic_event_flag && (pulse_mode || per_hit || per != 3'h0 && per != 3'h7));
  end

  // state register; the three reliability flags come up set
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q <= '0;
      q.power_on_flag <= 1'b1;
      q.osc_stop_flag <= 1'b1;
      q.low_battery_flag <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // pin outputs
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_crystal_freq_pin <= 1'b0;
      o_int_b_out <= 1'b0;
    end else begin
      o_crystal_freq_pin <= osc_freq;
      o_int_b_out <= 1'b0;  // open drain: only ever pulls low
    end
  end

  assign o_int_b_oe = q.int_oe;
endmodule : rtc_calendar_alarm_core
`default_nettype wire

// ==== tb/rtc_core_assertions.sv ====
/*
  rtc_core_checker: port properties of the timekeeping core.
  assumes it is bound to every core instance.
*/
`default_nettype none
module rtc_core_checker
  import rtc_pkg::*;
#(
  parameter int unsigned STOP_CYC = OSC_STOP_CYC
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // crystal and chip enable
  input wire logic i_osc,
  input wire logic i_ce,
  // watched outputs
  input wire logic o_so_oe,
  input wire logic o_int_b_out,
  input wire logic o_int_b_oe,
  input wire logic o_crystal_freq_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // end of a serial frame
  sequence frame_end;
    $fell(i_ce);
  endsequence
  // open drain: the pin value is always low
  int_value_a: assert property (o_int_b_out == 1'b0) else $error("int drives high");
  int_reset_a: assert property ($rose(i_rst_b) |-> !o_int_b_oe) else $error("int on at reset exit");
  // crystal copy follows the pin with a short fixed lag, never trimmed
  crystal_freq_out_rise_a: assert property ($rose(i_osc) |-> ##[1:8] o_crystal_freq_pin) else $error("crystal_freq_out no rise");
  crystal_freq_out_fall_a: assert property ($fell(i_osc) |-> ##[1:8] !o_crystal_freq_pin) else $error("crystal_freq_out no fall");
  crystal_freq_out_cause_a: assert property ($rose(o_crystal_freq_pin) |-> $past(i_osc)) else $error("crystal_freq_out early");
  crystal_freq_out_drop_a: assert property ($fell(o_crystal_freq_pin) |-> !$past(i_osc)) else $error("crystal_freq_out drop");
  // read data only inside a frame
  so_release_a: assert property (frame_end |-> ##[1:8] !o_so_oe) else $error("so held");
  so_start_a: assert property ($rose(o_so_oe) |-> i_ce) else $error("so outside frame");
endmodule : rtc_core_checker
bind rtc_calendar_alarm_core rtc_core_checker #(.STOP_CYC(STOP_CYC)) u_rtc_core_checker (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_osc(i_osc), .i_ce(i_ce), .o_so_oe(o_so_oe),
  .o_int_b_out(o_int_b_out), .o_int_b_oe(o_int_b_oe), .o_crystal_freq_pin(o_crystal_freq_pin)
);
`default_nettype wire

// ==== tb/serial_host_model.sv ====
/*
  serial_host_model: host on the four-wire bus, one frame per call.
  assumes the core takes data on rising sclk.
*/
`default_nettype none
module serial_host_model (
  // time base
  input wire logic i_clk,
  // serial pins
  output logic o_sclk,
  output logic o_si,
  output logic o_ce,
  input wire logic i_so
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HALF = 10; // 1 MHz, below the bus limit
  // idle bus
  initial begin
    o_sclk = 1'b0;
    o_si = 1'b0;
    o_ce = 1'b0;
  end
  // command byte then one data byte, msb first
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
    logic [15:0] sh;
    sh = {cmd, wd};
    rd = 8'h00;
    @(negedge i_clk);
    o_ce = 1'b1;
    repeat (HALF) @(negedge i_clk);
    for (int i = 15; i >= 0; i--) begin
      o_sclk = 1'b0;
      o_si = sh[i];
      repeat (HALF) @(negedge i_clk);
      o_sclk = 1'b1;
      rd = {rd[6:0], i_so};
      repeat (HALF) @(negedge i_clk);
    end
    o_sclk = 1'b0;
    repeat (HALF) @(negedge i_clk);
    o_ce = 1'b0;
    o_si = ~o_si; // released line must not keep its value
    repeat (2 * HALF) @(negedge i_clk);
  endtask : xfer
endmodule : serial_host_model
`default_nettype wire

// ==== tb/test_rtc_calendar_alarm_core.sv ====
/*
  test_rtc_calendar_alarm_core: register tests over the serial host.
  assumes a crystal model of 12 clocks a period.
*/
`default_nettype none
module test_rtc_calendar_alarm_core
  import rtc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_b, osc_run;
  logic osc = 1'b0;
  wire logic sclk, si, ce, so, so_oe, int_out, int_oe, crystal_freq_out;
  int num_errors = 0;
  int total_checks = 0;
  int div = 0;
  // address, written value, read value
  localparam logic [19:0] MASKS [6] = '{20'h3FF07, 20'h4FF3F, 20'h5FF1F, 20'h2FFBF, 20'hDA5A5, 20'h74141};
  rtc_calendar_alarm_core #(.STOP_CYC(64)) u_rtc_calendar_alarm_core (
    .i_clk(clk), .i_rst_b(rst_b), .i_osc(osc), .i_batt_low(1'b0), .i_sclk(sclk), .i_si(si),
    .i_ce(ce), .o_so(so), .o_so_oe(so_oe), .o_int_b_out(int_out), .o_int_b_oe(int_oe),
    .o_crystal_freq_pin(crystal_freq_out));
  // a released data line floats up to its pull-up level
  serial_host_model u_serial_host_model (.i_clk(clk), .o_sclk(sclk), .o_si(si), .o_ce(ce),
    .i_so(so_oe ? so : 1'b1));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // crystal stands still while stopped
  always @(negedge clk) begin
    if (osc_run) begin
      div <= (div == 5) ? 0 : div + 1;
      if (div == 5) osc <= ~osc;
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] unused;
    u_serial_host_model.xfer({a, 4'h0}, d, unused);
  endtask : wr
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input string what);
    logic [7:0] got;
    u_serial_host_model.xfer({a, 4'h8}, 8'h00, got);
    chk(got, exp, what);
  endtask : rd_chk
  // bounded wait for the interrupt pin to settle
  task automatic pin_chk(input logic exp, input string what);
    for (int n = 0; n < 50 && int_oe !== exp; n++) @(negedge clk);
    chk({7'h00, int_oe}, {7'h00, exp}, what);
  endtask : pin_chk
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize
  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    summarize();
  end
  initial begin
    rst_b = 1'b0;
    osc_run = 1'b1;
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    repeat (10) @(negedge clk);
    for (int a = 0; a < 16; a++) rd_chk(4'(a), (a == 15) ? 8'h70 : 8'h00, "reset value");
    pin_chk(1'b0, "int idle");
    $display("test reset done");
    wr(A_CTRL2, 8'h00);
    rd_chk(A_CTRL2, 8'h00, "flags cleared");
    wr(A_CTRL2, 8'h73);
    rd_chk(A_CTRL2, 8'h00, "flags set by host");
    osc_run = 1'b0;
    repeat (200) @(negedge clk);
    osc_run = 1'b1;
    rd_chk(A_CTRL2, 8'h20, "osc stop flag");
    wr(A_CTRL2, 8'h00);
    $display("test flags done");
    foreach (MASKS[i]) begin
      wr(MASKS[i][19:16], MASKS[i][15:8]);
      rd_chk(MASKS[i][19:16], MASKS[i][7:0], "masked write");
    end
    wr(A_MO_MIN, 8'h45);
    wr(A_CTRL2, 8'h80);
    rd_chk(A_SEC, 8'h00, "stamp");
    wr(A_WK_MIN, 8'hFF);
    rd_chk(A_WK_MIN, 8'h00, "reserved");
    wr(A_MO_MIN, 8'h95);
    rd_chk(A_MO_MIN, 8'h95, "alarm day");
    wr(A_MO_HOUR, 8'h92);
    rd_chk(A_MO_HOUR, 8'h92, "alarm month");
    rd_chk(A_RAM, 8'hA5, "ram in bank 1");
    wr(A_CTRL2, 8'h00);
    rd_chk(A_MO_MIN, 8'h45, "alarm minute");
    rd_chk(A_MO_HOUR, 8'h00, "alarm hour");
    $display("test registers done");
    wr(A_SEC, 8'h00);
    for (int c = 0; c < 8; c++) begin
      wr(A_CTRL1, 8'(c));
      pin_chk(c == 1 || c == 2, "periodic pin");
      rd_chk(A_CTRL2, (c == 1 || c == 2) ? 8'h04 : 8'h00, "periodic flag");
    end
    $display("test periodic done");
    summarize();
  end
endmodule : test_rtc_calendar_alarm_core
`default_nettype wire
